// [hw/nvsg_pkg.sv]
// Package for the nonvolatile SRAM mode-sequence host controller
package nvsg_pkg;
  // Bus geometry
  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;
  localparam int MODE_ADDR_W = 16;
  // Unlock prefix addresses
  localparam logic [15:0] SEQ_A1 = 16'h4E38;
  localparam logic [15:0] SEQ_A2 = 16'hB1C7;
  localparam logic [15:0] SEQ_A3 = 16'h83E0;
  localparam logic [15:0] SEQ_A4 = 16'h7C1F;
  localparam logic [15:0] SEQ_A5 = 16'h703F;
  // Final command addresses
  localparam logic [15:0] CMD_STORE = 16'h8FC0;
  localparam logic [15:0] CMD_RECALL = 16'h4C63;
  localparam logic [15:0] CMD_AS_OFF = 16'h8B45;
  localparam logic [15:0] CMD_AS_ON = 16'h4B46;
  // Timing: 40 MHz clock
  localparam int CLK_MHZ = 40;
  localparam int T_STORE_MS = 15;
  localparam int T_RECALL_MS = 20;
  localparam int STORE_CYC = T_STORE_MS * 1000 * CLK_MHZ;
  localparam int RECALL_CYC = T_RECALL_MS * 1000 * CLK_MHZ;
  // Read cycle: strobe low time in clocks (25 ns each, 3 covers 45 ns parts)
  localparam int RD_CYC = 3;
  localparam int WR_CYC = 3;
  // Power-on value of the autosave flag
  localparam logic AUTOSAVE_RST = 1'b1;
  // Commands from the user side
  typedef enum logic [2:0] {
    NVSG_OP_READ, NVSG_OP_WRITE, NVSG_OP_STORE, NVSG_OP_RECALL, NVSG_OP_AS_OFF, NVSG_OP_AS_ON
  } nvsg_op_t;
  // User request bundle
  typedef struct packed {
    nvsg_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0] be_n;
  } nvsg_req_t;
  // SRAM pin bundle driven by the host
  typedef struct packed {
    logic cs_n;
    logic we_n;
    logic oe_n;
    logic upper_byte_enable_n;
    logic lower_byte_enable_n;
    logic [ADDR_W-1:0] addr;
  } nvsg_pins_t;
endpackage

// [hw/nvsg_seq_rom.sv]
// Address lookup for each step of a mode command sequence
`timescale 1ns/1ps
`default_nettype none
module nvsg_seq_rom (
  // Step select
  input wire logic [2:0] step_i,
  input wire nvsg_pkg::nvsg_op_t op_i,
  // Address for that step
  output logic [nvsg_pkg::MODE_ADDR_W-1:0] addr_o
);
  // -----------------------------------------------
  // Step decode
  // -----------------------------------------------
  // Steps 0..4 are the fixed prefix, step 5 the command
  always_comb begin
    case (step_i)
      3'h0: addr_o = nvsg_pkg::SEQ_A1;
      3'h1: addr_o = nvsg_pkg::SEQ_A2;
      3'h2: addr_o = nvsg_pkg::SEQ_A3;
      3'h3: addr_o = nvsg_pkg::SEQ_A4;
      3'h4: addr_o = nvsg_pkg::SEQ_A5;
      default: begin
        case (op_i)
          nvsg_pkg::NVSG_OP_STORE: addr_o = nvsg_pkg::CMD_STORE;
          nvsg_pkg::NVSG_OP_RECALL: addr_o = nvsg_pkg::CMD_RECALL;
          nvsg_pkg::NVSG_OP_AS_OFF: addr_o = nvsg_pkg::CMD_AS_OFF;
          default: addr_o = nvsg_pkg::CMD_AS_ON;
        endcase
      end
    endcase
  end
endmodule // nvsg_seq_rom
`default_nettype wire

// [hw/nvsg_host.sv]
// Host controller driving a nonvolatile SRAM and issuing mode sequences
`timescale 1ns/1ps
`default_nettype none
// Function
// - Every command starts with five reads at 4E38, B1C7, 83E0, 7C1F, 703F in that order.
// - A sixth read at 8FC0 starts a store and the part leaves its data lines floating.
// - A sixth read at 4C63 starts a recall and the part leaves its data lines floating.
// - A sixth read at 8B45 switches the power-down autosave off.
// - A sixth read at 4B46 switches the power-down autosave back on.
// - The host holds the write strobe high over all six sequence reads.
// - The host issues the six addresses back to back in the listed order.
// - After changing the autosave setting a store must follow for it to persist.
module nvsg_host #(
  parameter int ADDR_W = nvsg_pkg::ADDR_W,
  parameter int STORE_CYC = nvsg_pkg::STORE_CYC,
  parameter int RECALL_CYC = nvsg_pkg::RECALL_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // User request and answer
  input wire logic req_valid_i,
  input wire nvsg_pkg::nvsg_req_t req_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [nvsg_pkg::DATA_W-1:0] rsp_rdata_o,
  // Supply status from the board
  input wire logic supply_low_i,
  // SRAM pins
  output nvsg_pkg::nvsg_pins_t pins_o,
  input wire logic [nvsg_pkg::DATA_W-1:0] dq_i,
  output logic [nvsg_pkg::DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  input wire logic hw_store_busy_n_i,
  // Host view of the part's autosave setting
  output logic power_down_autosave_o,
  output logic autosave_unsaved_o
);
  // -----------------------------------------------
  // Elaboration checks
  // -----------------------------------------------
  if (ADDR_W < nvsg_pkg::MODE_ADDR_W || ADDR_W > nvsg_pkg::ADDR_W) begin : g_chk_addr
    $error("ADDR_W out of range");
  end
  if (STORE_CYC < 1 || RECALL_CYC < 1) begin : g_chk_cyc
    $error("busy counts must be positive");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_GAP, ST_BUSY} nvsg_state_t;

  localparam int CNT_W = 32;
  // Step code that marks a plain access or autosave command as finished; the gap then returns to idle
  localparam logic [2:0] STEP_DONE = 3'h6;

  // Current access and its progress
  nvsg_state_t state_q;
  nvsg_pkg::nvsg_req_t cur_q;
  logic [2:0] step_q;
  logic [CNT_W-1:0] cnt_q;
  logic [15:0] seq_addr;
  logic is_seq;

  // Sequence address table
  nvsg_seq_rom u_rom (
    .step_i(step_q),
    .op_i(cur_q.op),
    .addr_o(seq_addr)
  );

  // Pick the strobe length for the current access
  function automatic logic [CNT_W-1:0] strobe_len(input nvsg_pkg::nvsg_op_t op);
    strobe_len = (op == nvsg_pkg::NVSG_OP_WRITE) ? CNT_W'(nvsg_pkg::WR_CYC) : CNT_W'(nvsg_pkg::RD_CYC);
  endfunction

  // Anything but a plain read or write is a six-read mode sequence
  assign is_seq = (cur_q.op != nvsg_pkg::NVSG_OP_READ) && (cur_q.op != nvsg_pkg::NVSG_OP_WRITE);

  // -----------------------------------------------
  // Access sequencer
  // -----------------------------------------------
  // One request at a time; a sequence runs all six reads without giving way, so nothing can interleave
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      cur_q <= '0;
      step_q <= 3'h0;
      cnt_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          // low supply: hold store and write requests back
          // A busy part refuses every access, so nothing is taken until its pin rises
          if (req_valid_i && !(supply_low_i && (req_i.op == nvsg_pkg::NVSG_OP_WRITE ||
              req_i.op == nvsg_pkg::NVSG_OP_STORE)) && hw_store_busy_n_i) begin
            cur_q <= req_i;
            step_q <= 3'h0;
            state_q <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          // Load the strobe length at the same edge at which select and read strobe fall
          cnt_q <= strobe_len(cur_q.op);
          state_q <= ST_STROBE;
        end
        ST_STROBE: begin
          if (cnt_q > CNT_W'(1)) begin
            cnt_q <= cnt_q - CNT_W'(1);
          end else if (is_seq && step_q != 3'h5) begin
            // back to back: next step follows after the one-clock gap
            step_q <= step_q + 3'h1;
            state_q <= ST_GAP;
          end else if (cur_q.op == nvsg_pkg::NVSG_OP_STORE) begin
            cnt_q <= CNT_W'(STORE_CYC);
            state_q <= ST_BUSY;
          end else if (cur_q.op == nvsg_pkg::NVSG_OP_RECALL) begin
            cnt_q <= CNT_W'(RECALL_CYC);
            state_q <= ST_BUSY;
          end else begin
            // Plain access or autosave command done; without this marker the
            // sixth read of an autosave command would be repeated for ever
            step_q <= STEP_DONE;
            state_q <= ST_GAP;
          end
        end
        ST_GAP: begin
          // Strobes high one clock so the part sees a fresh falling edge
          // Unfinished sequences go on to their next read
          state_q <= (is_seq && step_q != STEP_DONE) ? ST_SETUP : ST_IDLE;
        end
        ST_BUSY: begin
          // The part may outlast the count; its busy pin has the last word
          if (cnt_q > CNT_W'(1)) begin
            cnt_q <= cnt_q - CNT_W'(1);
          end else if (hw_store_busy_n_i) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // -----------------------------------------------
  // Pin drive
  // -----------------------------------------------
  // All pins registered; select low from ST_SETUP on, write strobe only in ST_STROBE, read strobe stays low one clock longer than select
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pins_o <= '{cs_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, upper_byte_enable_n: 1'b1,
                  lower_byte_enable_n: 1'b1, addr: '0};
      dq_o <= '0;
      dq_oe_o <= 1'b0;
    end else begin
      // Select rises at the last strobe clock, the edge at which read data is taken
      pins_o.cs_n <= !(state_q == ST_SETUP || state_q == ST_STROBE) || (state_q == ST_STROBE && cnt_q <= CNT_W'(1));
      // write strobe held high for sequence reads
      pins_o.we_n <= !(cur_q.op == nvsg_pkg::NVSG_OP_WRITE && state_q == ST_STROBE && cnt_q > CNT_W'(1));
      pins_o.oe_n <= !(state_q == ST_SETUP || state_q == ST_STROBE) || cur_q.op == nvsg_pkg::NVSG_OP_WRITE;
      pins_o.upper_byte_enable_n <= is_seq ? 1'b0 : cur_q.be_n[1];
      pins_o.lower_byte_enable_n <= is_seq ? 1'b0 : cur_q.be_n[0];
      // sequence address on the low 16 bits, upper bits zero
      pins_o.addr <= is_seq ? {{(nvsg_pkg::ADDR_W - 16){1'b0}}, seq_addr} : cur_q.addr;
      // Write data simply follows the request; dq_oe_o alone decides when it reaches the pins
      dq_o <= cur_q.wdata;
      dq_oe_o <= (cur_q.op == nvsg_pkg::NVSG_OP_WRITE) && (state_q == ST_SETUP || state_q == ST_STROBE);
    end
  end

  // -----------------------------------------------
  // Answer path
  // -----------------------------------------------
  // Read data captured at the last strobe clock; a command answers once it is finished
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= '0;
      req_ready_o <= 1'b0;
    end else begin
      // Only the finished gap or the end of the busy wait answer; the gaps
      // between sequence reads stay silent or the user would leave early
      rsp_valid_o <= (state_q == ST_GAP && step_q == STEP_DONE) ||
                     (state_q == ST_BUSY && cnt_q <= CNT_W'(1) && hw_store_busy_n_i);
      // Taken at the edge that raises select, while the part still drives
      if (state_q == ST_STROBE && cnt_q <= CNT_W'(1)) begin
        rsp_rdata_o <= dq_i;
      end
      // Informational only: low while a request is being taken or work is under way
      req_ready_o <= (state_q == ST_IDLE) && !(req_valid_i && hw_store_busy_n_i);
    end
  end

  // -----------------------------------------------
  // Autosave shadow
  // -----------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      power_down_autosave_o <= nvsg_pkg::AUTOSAVE_RST;
      autosave_unsaved_o <= 1'b0;
    end else if (state_q == ST_STROBE && cnt_q <= CNT_W'(1) && step_q == 3'h5) begin
      // Shadow follows the sixth read, the moment the part acts on the command
      if (cur_q.op == nvsg_pkg::NVSG_OP_AS_OFF || cur_q.op == nvsg_pkg::NVSG_OP_AS_ON) begin
        power_down_autosave_o <= (cur_q.op == nvsg_pkg::NVSG_OP_AS_ON);
        // flag that a store is still owed
        autosave_unsaved_o <= 1'b1;
      end else if (cur_q.op == nvsg_pkg::NVSG_OP_STORE) begin
        autosave_unsaved_o <= 1'b0;
      end
    end
  end
endmodule // nvsg_host
`default_nettype wire

// [verification/nvsg_host_monitor.sv]
// Checker of pin-level rules kept by the mode-sequence host controller
`timescale 1ns/1ps
`default_nettype none
module nvsg_host_monitor (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Watched ports
  input wire logic rsp_valid_o,
  input wire logic supply_low_i,
  input wire nvsg_pkg::nvsg_pins_t pins_o,
  input wire logic dq_oe_o,
  input wire logic hw_store_busy_n_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Read strobe never overlaps the write strobe
  a_rd_we_high: assert property (!pins_o.oe_n |-> pins_o.we_n)
    else $error("read strobe with write strobe low");
  a_no_bus_fight: assert property (dq_oe_o |-> pins_o.oe_n)
    else $error("host drives data while part may drive");
  a_addr_stable: assert property (!pins_o.cs_n && $past(!pins_o.cs_n) |-> $stable(pins_o.addr))
    else $error("address moved inside an access");
  a_strobe_len: assert property ($fell(pins_o.cs_n) |=> !pins_o.cs_n)
    else $error("select pulse too short");
  a_rsp_pulse: assert property (rsp_valid_o |=> !rsp_valid_o)
    else $error("answer longer than one cycle");
  a_we_needs_cs: assert property (!pins_o.we_n |-> !pins_o.cs_n)
    else $error("write strobe without select");
  // Low supply held for a while: no write may start
  a_lowv_no_write: assert property (supply_low_i && $past(supply_low_i, 8) |-> pins_o.we_n)
    else $error("write under low supply");
  a_busy_no_access: assert property (!hw_store_busy_n_i && $past(!hw_store_busy_n_i) |-> pins_o.cs_n)
    else $error("access while part busy");
endmodule // nvsg_host_monitor
bind nvsg_host nvsg_host_monitor u_mon (.clk_i(clk_i), .rst_n_i(rst_n_i), .rsp_valid_o(rsp_valid_o),
  .supply_low_i(supply_low_i), .pins_o(pins_o), .dq_oe_o(dq_oe_o), .hw_store_busy_n_i(hw_store_busy_n_i));
`default_nettype wire

// [verification/nvsg_sram_model.sv]
// Behavioural model of the nonvolatile SRAM as seen from the host
`timescale 1ns/1ps
`default_nettype none
module nvsg_sram_model #(
  parameter int BUSY_CYC = 30
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Host side
  input wire nvsg_pkg::nvsg_pins_t pins_i,
  input wire logic [15:0] dq_i,
  input wire logic supply_low_i,
  // Part outputs
  output logic [15:0] dq_o,
  output logic busy_n_o,
  output logic autosave_o
);
  localparam logic [15:0] SEQ [5] = '{nvsg_pkg::SEQ_A1, nvsg_pkg::SEQ_A2, nvsg_pkg::SEQ_A3,
    nvsg_pkg::SEQ_A4, nvsg_pkg::SEQ_A5};
  logic [15:0] mem_q [256];
  logic [15:0] nv_q [256];
  logic [15:0] last_q, a_q;
  logic [2:0] step_q;
  logic cs_q, we_q, arm_q, as_nv_q, fall, rd_end;
  int cnt_q;
  // Pins are sampled one edge late, so edges are seen against last cycle
  assign busy_n_o = (cnt_q == 0);
  assign fall = (cs_q & ~pins_i.cs_n) | (we_q & ~pins_i.we_n);
  assign rd_end = ~cs_q & pins_i.cs_n & we_q;
  always_comb begin
    dq_o = ~last_q; // Undriven lanes flip so a stale value never passes
    if (!pins_i.cs_n && !pins_i.oe_n && pins_i.we_n && busy_n_o) begin
      if (!pins_i.upper_byte_enable_n) dq_o[15:8] = mem_q[pins_i.addr[7:0]][15:8];
      if (!pins_i.lower_byte_enable_n) dq_o[7:0] = mem_q[pins_i.addr[7:0]][7:0];
    end
  end
  // Access, sequence and nonvolatile state
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_q <= 1'b1;
      we_q <= 1'b1;
      arm_q <= 1'b0;
      step_q <= 3'h0;
      cnt_q <= 0;
      last_q <= 16'h0;
      autosave_o <= 1'b1;
    end else begin
      cs_q <= pins_i.cs_n;
      we_q <= pins_i.we_n;
      last_q <= dq_o;
      if (!pins_i.cs_n) a_q <= pins_i.addr[15:0];
      if (cnt_q != 0) begin
        cnt_q <= cnt_q - 1;
        arm_q <= 1'b0;
      end else if (!pins_i.cs_n && !pins_i.we_n) begin
        step_q <= 3'h0;
        if ((fall || arm_q) && !supply_low_i) begin
          if (!pins_i.upper_byte_enable_n) mem_q[pins_i.addr[7:0]][15:8] <= dq_i[15:8];
          if (!pins_i.lower_byte_enable_n) mem_q[pins_i.addr[7:0]][7:0] <= dq_i[7:0];
          arm_q <= 1'b1;
        end
      end else if (rd_end && step_q == 3'h5) begin
        step_q <= (a_q == nvsg_pkg::SEQ_A1) ? 3'h1 : 3'h0;
        case (a_q)
          nvsg_pkg::CMD_STORE: if (!supply_low_i) begin
            nv_q <= mem_q;
            as_nv_q <= autosave_o;
            cnt_q <= BUSY_CYC;
          end
          nvsg_pkg::CMD_RECALL: begin
            mem_q <= nv_q;
            cnt_q <= BUSY_CYC;
          end
          nvsg_pkg::CMD_AS_OFF: autosave_o <= 1'b0;
          nvsg_pkg::CMD_AS_ON: autosave_o <= 1'b1;
          default: ;
        endcase
      end else if (rd_end) begin
        step_q <= (a_q == SEQ[step_q]) ? step_q + 3'h1 : ((a_q == nvsg_pkg::SEQ_A1) ? 3'h1 : 3'h0);
      end
    end
  end
endmodule // nvsg_sram_model
`default_nettype wire

// [verification/nvsg_host_tb.sv]
// Self-checking bench for the mode-sequence host controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin err_count++; $display("BAD %s exp %h got %h", n, e, a); end end
module nvsg_host_tb;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic req_valid_i = 1'b0;
  logic supply_low_i = 1'b0;
  nvsg_pkg::nvsg_req_t req_i = '0;
  nvsg_pkg::nvsg_pins_t pins;
  logic rsp_valid, busy_n, pd_as, unsaved, part_as, rdy;
  logic [15:0] rsp_rdata, dq_p, dq_h, rd;
  int err_count = 0;
  int checked = 0;
  int busy_seen = 0;
  always #12.5 clk_i = ~clk_i;
  always @(negedge busy_n) busy_seen++;
  // Short nonvolatile counts; part stays busy longer so the pin is waited on
  nvsg_host #(.STORE_CYC(20), .RECALL_CYC(20)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(rdy), .rsp_valid_o(rsp_valid), .rsp_rdata_o(rsp_rdata),
    .supply_low_i(supply_low_i), .pins_o(pins), .dq_i(dq_p), .dq_o(dq_h), .dq_oe_o(), .hw_store_busy_n_i(busy_n),
    .power_down_autosave_o(pd_as), .autosave_unsaved_o(unsaved));
  nvsg_sram_model #(.BUSY_CYC(30)) u_part (.clk_i(clk_i), .rst_n_i(rst_n_i), .pins_i(pins), .dq_i(dq_h),
    .supply_low_i(supply_low_i), .dq_o(dq_p), .busy_n_o(busy_n), .autosave_o(part_as));
  // Wait for the answer, then drop the request in that cycle
  task automatic wait_rsp();
    int n;
    n = 0;
    do begin @(posedge clk_i); #2; n++; end while (rsp_valid !== 1'b1 && n < 4000);
    req_valid_i = 1'b0;
    rd = rsp_rdata;
    if (n >= 4000) `CHK("answer", 1'b1, 1'b0)
  endtask
  task automatic op(input nvsg_pkg::nvsg_op_t o, input logic [18:0] ad, input logic [15:0] wd,
                    input logic [1:0] be = 2'b00);
    @(posedge clk_i);
    #2;
    req_i = '{op: o, addr: ad, wdata: wd, be_n: be};
    req_valid_i = 1'b1;
    wait_rsp();
  endtask
  task automatic t_rw();
    op(nvsg_pkg::NVSG_OP_WRITE, 19'h7FF05, 16'hA5C3);
    op(nvsg_pkg::NVSG_OP_READ, 19'h7FF05, 16'h0);
    `CHK("read back", 16'hA5C3, rd)
    op(nvsg_pkg::NVSG_OP_WRITE, 19'h7FF05, 16'h5A00, 2'b01);
    op(nvsg_pkg::NVSG_OP_READ, 19'h7FF05, 16'h0, 2'b10);
    `CHK("lower lane", 8'hC3, rd[7:0])
    op(nvsg_pkg::NVSG_OP_READ, 19'h7FF05, 16'h0);
    `CHK("upper lane", 16'h5AC3, rd)
    @(posedge clk_i);
    #2;
    `CHK("ready idle", 1'b1, rdy)
    $display("test rw done");
  endtask
  task automatic t_nv();
    int b;
    b = busy_seen;
    op(nvsg_pkg::NVSG_OP_WRITE, 19'h1, 16'h1111);
    op(nvsg_pkg::NVSG_OP_STORE, 19'h0, 16'h0);
    op(nvsg_pkg::NVSG_OP_STORE, 19'h0, 16'h0);
    `CHK("store count", b + 2, busy_seen)
    op(nvsg_pkg::NVSG_OP_WRITE, 19'h1, 16'h2222);
    op(nvsg_pkg::NVSG_OP_RECALL, 19'h0, 16'h0);
    `CHK("part idle", 1'b1, busy_n)
    op(nvsg_pkg::NVSG_OP_READ, 19'h1, 16'h0);
    `CHK("recalled", 16'h1111, rd)
    $display("test nv done");
  endtask
  task automatic t_as();
    op(nvsg_pkg::NVSG_OP_AS_OFF, 19'h0, 16'h0);
    `CHK("shadow off", 1'b0, pd_as)
    `CHK("part off", 1'b0, part_as)
    `CHK("unsaved set", 1'b1, unsaved)
    op(nvsg_pkg::NVSG_OP_AS_ON, 19'h0, 16'h0);
    `CHK("shadow on", 1'b1, pd_as)
    `CHK("part on", 1'b1, part_as)
    op(nvsg_pkg::NVSG_OP_STORE, 19'h0, 16'h0);
    `CHK("unsaved clear", 1'b0, unsaved)
    $display("test autosave done");
  endtask
  task automatic t_lowv();
    logic hit;
    hit = 1'b0;
    @(posedge clk_i);
    #2;
    supply_low_i = 1'b1;
    req_i = '{op: nvsg_pkg::NVSG_OP_WRITE, addr: 19'h2, wdata: 16'h7777, be_n: 2'b00};
    req_valid_i = 1'b1;
    repeat (40) begin @(posedge clk_i); #2; hit = hit | rsp_valid | ~pins.we_n; end
    `CHK("held under low supply", 1'b0, hit)
    supply_low_i = 1'b0;
    wait_rsp();
    op(nvsg_pkg::NVSG_OP_READ, 19'h2, 16'h0);
    `CHK("late write", 16'h7777, rd)
    $display("test low supply done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Watchdog: runs are well under a thousand cycles per test
  initial begin
    #(20000 * 25);
    err_count++;
    results();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    #2;
    rst_n_i = 1'b1;
    `CHK("shadow at reset", 1'b1, pd_as)
    t_rw();
    t_nv();
    t_as();
    t_lowv();
    results();
  end
endmodule // nvsg_host_tb
`default_nettype wire
